// ==== src/rcts_pkg.sv ====
// rcts_pkg: register map, field layout, reset values, timing and types of the rc clock trim and switch block
package rcts_pkg;
  // register offsets on the local register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_TRIM_HIGH = 4'h0;
  localparam logic [3:0] OFS_TRIM_LOW = 4'h1;
  localparam logic [3:0] OFS_PROG_CTRL = 4'h2;
  localparam logic [3:0] OFS_USER_HIGH = 4'h3;
  localparam logic [3:0] OFS_USER_LOW = 4'h4;
  localparam logic [3:0] OFS_CLK_CSR = 4'h5;
  localparam logic [3:0] OFS_FACT_HIGH = 4'h6;
  localparam logic [3:0] OFS_FACT_LOW = 4'h7;
  // field positions
  localparam int TRIM_LOW_LSB = 5;
  localparam int TRIM_LOW_MSB = 6;
  localparam int PGM_BIT = 0;
  localparam int LAT_BIT = 1;
  localparam int CSR_SEL_BIT = 0;
  localparam int CSR_INTERNAL_RC_ACTIVE_FLAG_BIT = 1;
  localparam int CSR_WAKEUP_OSC_ACTIVE_FLAG_BIT = 2;
  // reset and erased values
  localparam logic [7:0] TRIM_HIGH_RST = 8'hff;
  localparam logic [7:0] TRIM_LOW_RST = 8'hff;
  localparam logic [7:0] PROG_CTRL_RST = 8'h00;
  localparam logic [7:0] NVM_ERASED = 8'hff;
  // startup clock option codes
  localparam logic [1:0] CKSEL_RC = 2'b00;
  localparam logic [1:0] CKSEL_AWU = 2'b01;
  // switching counts in oscillator ticks
  localparam logic [3:0] AWU_SET_TICKS = 4'h3;
  localparam logic [3:0] RC_WAIT_TICKS = 4'h8;
  localparam logic [3:0] INTERNAL_RC_ACTIVE_FLAG_TICKS = 4'h2;
  // non-volatile programming time
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * (SYS_CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_RC = 3'b001,
    ST_TO_AWU = 3'b010,
    ST_AWU = 3'b011,
    ST_TO_RC_CNT = 3'b100,
    ST_TO_RC_AWUCLR = 3'b101,
    ST_TO_INTERNAL_RC_ACTIVE_FLAG = 3'b110,
    ST_EXT = 3'b111
  } rcts_clk_state_t;

  typedef struct packed {
    logic rc_en;
    logic awu_en;
    logic xtal_en;
    logic src_awu;
    logic hold_high;
  } rcts_osc_ctrl_t;
endpackage : rcts_pkg

// ==== src/rcts_top.sv ====
// rcts_top: oscillator trim registers, user trim programming and glitch-free clock_select_bit clock switch
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module rcts_top
  import rcts_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES,
  parameter logic [7:0] FACT_HIGH_P = 8'h80, // arbitrary value
  parameter logic [7:0] FACT_LOW_P = 8'h40 // arbitrary value
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic rd_drive_o,
  // option bytes and system state
  input wire logic [1:0] startup_clock_select_i,
  input wire logic programming_port_i,
  input wire logic readout_prot_i,
  input wire logic readout_prot_removed_i,
  input wire logic auto_wakeup_halt_i,
  // oscillator edge ticks
  input wire logic rc_tick_i,
  input wire logic awu_tick_i,
  // oscillator control and trim
  output rcts_osc_ctrl_t osc_ctrl_o,
  output logic [9:0] trim_value_o
);

  localparam int PCNT_W = $clog2(PROG_CYCLES_P + 1);

  if (PROG_CYCLES_P < 2) begin : g_bad_prog
    $error("PROG_CYCLES_P must be at least 2");
  end

  function automatic logic [9:0] trim_pack(input logic [7:0] hi, input logic [7:0] lo);
    trim_pack = {hi, lo[TRIM_LOW_MSB:TRIM_LOW_LSB]};
  endfunction : trim_pack

  function automatic logic is_user(input logic [ADDR_W-1:0] a);
    is_user = (a == OFS_USER_HIGH) || (a == OFS_USER_LOW);
  endfunction : is_user

  logic [7:0] rc_trim_high_ff;
  logic [7:0] rc_trim_low_ff;
  logic latch_enable_bit_ff;
  logic program_start_bit_ff;
  logic [7:0] latch_high_ff;
  logic [7:0] latch_low_ff;
  logic [7:0] nvm_user_ff [2];
  logic [PCNT_W-1:0] prog_cnt_ff;
  logic clock_select_bit_ff;
  logic internal_rc_active_flag_ff;
  logic wakeup_osc_active_flag_ff;
  rcts_clk_state_t state_ff;
  logic [3:0] tick_cnt_ff;
  logic prog_done;
  logic wr_user;
  logic [7:0] nxt_rd_data;
  logic nxt_rd_drive;

  assign wr_user = wr_i && is_user(addr_i);
  assign prog_done = program_start_bit_ff && (prog_cnt_ff == PCNT_W'(1));

  // trim registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rc_trim_high_ff <= TRIM_HIGH_RST;
      rc_trim_low_ff <= TRIM_LOW_RST;
    end else if (ce_i && wr_i) begin
      if (addr_i == OFS_TRIM_HIGH) begin
        rc_trim_high_ff <= wr_data_i;
      end
      if (addr_i == OFS_TRIM_LOW) begin
        rc_trim_low_ff <= wr_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      trim_value_o <= trim_pack(TRIM_HIGH_RST, TRIM_LOW_RST);
    end else if (ce_i) begin
      trim_value_o <= trim_pack(rc_trim_high_ff, rc_trim_low_ff);
    end
  end

  // programming control bits
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      latch_enable_bit_ff <= PROG_CTRL_RST[LAT_BIT];
      program_start_bit_ff <= PROG_CTRL_RST[PGM_BIT];
      prog_cnt_ff <= '0;
    end else if (ce_i) begin
      if (prog_done) begin
        latch_enable_bit_ff <= 1'b0;
        program_start_bit_ff <= 1'b0;
        prog_cnt_ff <= '0;
      end else if (program_start_bit_ff) begin
        // control writes are ignored while a cycle runs
        prog_cnt_ff <= prog_cnt_ff - PCNT_W'(1);
      end else if (wr_i && addr_i == OFS_PROG_CTRL) begin
        latch_enable_bit_ff <= wr_data_i[LAT_BIT];
        if (wr_data_i[PGM_BIT] && latch_enable_bit_ff && !readout_prot_i) begin
          program_start_bit_ff <= 1'b1;
          prog_cnt_ff <= PCNT_W'(PROG_CYCLES_P);
        end
      end
    end
  end

  // data latches for the user bytes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      latch_high_ff <= NVM_ERASED;
      latch_low_ff <= NVM_ERASED;
    end else if (ce_i && wr_user && latch_enable_bit_ff && !program_start_bit_ff && !readout_prot_i) begin
      if (addr_i == OFS_USER_HIGH) begin
        latch_high_ff <= wr_data_i;
      end else begin
        latch_low_ff <= wr_data_i;
      end
    end
  end

  // non-volatile user cells: no reset; high byte at start, low byte at end,
  // so a reset mid-cycle leaves a mixed pair
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (readout_prot_removed_i) begin
        nvm_user_ff[0] <= NVM_ERASED;
        nvm_user_ff[1] <= NVM_ERASED;
      end else if (rst_n_i && prog_done) begin
        nvm_user_ff[1] <= latch_low_ff;
      end else if (rst_n_i && !program_start_bit_ff && wr_i && addr_i == OFS_PROG_CTRL && wr_data_i[PGM_BIT]
                   && latch_enable_bit_ff && !readout_prot_i) begin
        nvm_user_ff[0] <= latch_high_ff;
      end
    end
  end

  // read mux
  always_comb begin
    nxt_rd_data = 8'h00;
    nxt_rd_drive = 1'b1;
    case (addr_i)
      OFS_TRIM_HIGH: nxt_rd_data = rc_trim_high_ff;
      OFS_TRIM_LOW: nxt_rd_data = rc_trim_low_ff;
      OFS_PROG_CTRL: nxt_rd_data = {6'h00, latch_enable_bit_ff, program_start_bit_ff};
      OFS_USER_HIGH, OFS_USER_LOW: begin
        if (latch_enable_bit_ff || readout_prot_i) begin
          nxt_rd_drive = 1'b0;
        end else begin
          nxt_rd_data = (addr_i == OFS_USER_HIGH) ? nvm_user_ff[0] : nvm_user_ff[1];
        end
      end
      OFS_CLK_CSR: nxt_rd_data = {5'h00, wakeup_osc_active_flag_ff, internal_rc_active_flag_ff, clock_select_bit_ff};
      OFS_FACT_HIGH: nxt_rd_data = FACT_HIGH_P;
      OFS_FACT_LOW: nxt_rd_data = FACT_LOW_P;
      default: nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
      rd_drive_o <= 1'b0;
    end else if (ce_i) begin
      rd_data_o <= rd_i ? nxt_rd_data : 8'h00;
      rd_drive_o <= rd_i && nxt_rd_drive;
    end
  end

  // software clock select bit
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      clock_select_bit_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == ST_INIT) begin
        clock_select_bit_ff <= (startup_clock_select_i == CKSEL_AWU);
      end else if (wr_i && addr_i == OFS_CLK_CSR) begin
        clock_select_bit_ff <= wr_data_i[CSR_SEL_BIT];
      end
    end
  end

  // clock switch sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_INIT;
      tick_cnt_ff <= 4'h0;
      internal_rc_active_flag_ff <= 1'b0;
      wakeup_osc_active_flag_ff <= 1'b0;
      osc_ctrl_o <= '{rc_en: 1'b1, awu_en: 1'b0, xtal_en: 1'b1, src_awu: 1'b0, hold_high: 1'b0};
    end else if (ce_i) begin
      if (programming_port_i) begin
        state_ff <= ST_RC;
        tick_cnt_ff <= 4'h0;
        internal_rc_active_flag_ff <= 1'b1;
        wakeup_osc_active_flag_ff <= 1'b0;
        osc_ctrl_o.rc_en <= 1'b1;
        osc_ctrl_o.src_awu <= 1'b0;
        osc_ctrl_o.hold_high <= 1'b0;
      end else begin
        case (state_ff)
          ST_INIT: begin
            osc_ctrl_o.xtal_en <= !(startup_clock_select_i inside {CKSEL_RC, CKSEL_AWU});
            if (startup_clock_select_i == CKSEL_AWU) begin
              state_ff <= ST_AWU;
              wakeup_osc_active_flag_ff <= 1'b1;
              osc_ctrl_o.awu_en <= 1'b1;
              osc_ctrl_o.rc_en <= 1'b0;
              osc_ctrl_o.src_awu <= 1'b1;
            end else if (startup_clock_select_i == CKSEL_RC) begin
              state_ff <= ST_RC;
              internal_rc_active_flag_ff <= 1'b1;
            end else begin
              state_ff <= ST_EXT;
              osc_ctrl_o.rc_en <= 1'b0;
              osc_ctrl_o.awu_en <= 1'b1;
            end
          end
          ST_RC: begin
            osc_ctrl_o.rc_en <= 1'b1;
            osc_ctrl_o.awu_en <= auto_wakeup_halt_i;
            if (clock_select_bit_ff) begin
              state_ff <= ST_TO_AWU;
              tick_cnt_ff <= 4'h0;
              internal_rc_active_flag_ff <= 1'b0;
              osc_ctrl_o.hold_high <= 1'b1;
              osc_ctrl_o.awu_en <= 1'b1;
            end
          end
          ST_TO_AWU: begin
            if (awu_tick_i) begin
              tick_cnt_ff <= tick_cnt_ff + 4'h1;
              if (tick_cnt_ff == AWU_SET_TICKS - 4'h1) begin
                state_ff <= ST_AWU;
                wakeup_osc_active_flag_ff <= 1'b1;
                osc_ctrl_o.src_awu <= 1'b1;
                osc_ctrl_o.hold_high <= 1'b0;
              end
            end
          end
          ST_AWU: begin
            osc_ctrl_o.rc_en <= 1'b0;
            if (!clock_select_bit_ff) begin
              state_ff <= ST_TO_RC_CNT;
              tick_cnt_ff <= 4'h0;
              osc_ctrl_o.rc_en <= 1'b1;
            end
          end
          ST_TO_RC_CNT: begin
            if (rc_tick_i) begin
              tick_cnt_ff <= tick_cnt_ff + 4'h1;
              if (tick_cnt_ff == RC_WAIT_TICKS - 4'h1) begin
                state_ff <= ST_TO_RC_AWUCLR;
              end
            end
          end
          ST_TO_RC_AWUCLR: begin
            if (awu_tick_i) begin
              state_ff <= ST_TO_INTERNAL_RC_ACTIVE_FLAG;
              tick_cnt_ff <= 4'h0;
              wakeup_osc_active_flag_ff <= 1'b0;
              osc_ctrl_o.hold_high <= 1'b1;
            end
          end
          ST_TO_INTERNAL_RC_ACTIVE_FLAG: begin
            if (rc_tick_i) begin
              tick_cnt_ff <= tick_cnt_ff + 4'h1;
              if (tick_cnt_ff == INTERNAL_RC_ACTIVE_FLAG_TICKS - 4'h1) begin
                state_ff <= ST_RC;
                internal_rc_active_flag_ff <= 1'b1;
                osc_ctrl_o.src_awu <= 1'b0;
                osc_ctrl_o.hold_high <= 1'b0;
                osc_ctrl_o.awu_en <= auto_wakeup_halt_i;
              end
            end
          end
          ST_EXT: begin
            osc_ctrl_o.awu_en <= 1'b1;
            osc_ctrl_o.rc_en <= 1'b0;
          end
          default: state_ff <= ST_INIT;
        endcase
      end
    end
  end

  // checks
  trim_pack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && $past(rst_n_i) |=> trim_value_o == {$past(rc_trim_high_ff), $past(rc_trim_low_ff[6:5])})
    else $error("trim value not formed from trim registers");

  trim_reset_a: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> rc_trim_high_ff == 8'hff && rc_trim_low_ff == 8'hff)
    else $error("trim registers not at ffh after reset");

  prog_done_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(program_start_bit_ff) |-> $fell(latch_enable_bit_ff))
    else $error("program and latch bits not cleared together");

  force_rc_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && programming_port_i |=> !osc_ctrl_o.src_awu && osc_ctrl_o.rc_en && internal_rc_active_flag_ff)
    else $error("programming port did not force internal rc");

  read_undriven_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && is_user(addr_i) && latch_enable_bit_ff |=> !rd_drive_o && rd_data_o == 8'h00)
    else $error("user byte read drove bus while latching");

  no_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_user && !latch_enable_bit_ff |=> $stable(latch_high_ff) && $stable(latch_low_ff))
    else $error("user byte latched without latch enable");

  lat_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && program_start_bit_ff && !prog_done |=> latch_enable_bit_ff && program_start_bit_ff)
    else $error("latch bit cleared during programming");

  awu_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && !programming_port_i && state_ff == ST_RC && clock_select_bit_ff
    |=> !internal_rc_active_flag_ff && osc_ctrl_o.hold_high && !wakeup_osc_active_flag_ff)
    else $error("switch to wakeup did not drop internal_rc_active_flag and hold clock");

  rc_count_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_TO_RC_CNT |-> tick_cnt_ff < RC_WAIT_TICKS)
    else $error("rc wait counter passed eight ticks");

  rc_stopped_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && !programming_port_i && state_ff == ST_AWU && clock_select_bit_ff ##1 state_ff == ST_AWU
    |-> !osc_ctrl_o.rc_en && osc_ctrl_o.src_awu)
    else $error("internal rc running while wakeup clock selected");

  ext_awu_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_ff == ST_EXT ##1 state_ff == ST_EXT |-> osc_ctrl_o.awu_en && osc_ctrl_o.xtal_en)
    else $error("wakeup osc off with external clock");

endmodule : rcts_top
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: register-level checks of the rc clock trim and switch block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import rcts_pkg::*;
;
  localparam int PROG_N = 8;
  logic sys_clk_i, rst_n_i, ce_i, wr_i, rd_i, rd_drive_o;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0] wr_data_i, rd_data_o, rv;
  logic [1:0] startup_clock_select_i;
  logic programming_port_i, readout_prot_i, readout_prot_removed_i, auto_wakeup_halt_i;
  logic rc_tick_i, awu_tick_i, dv;
  rcts_osc_ctrl_t osc_ctrl_o;
  logic [9:0] trim_value_o;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;

  rcts_top #(.PROG_CYCLES_P(PROG_N)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .rd_drive_o(rd_drive_o),
    .startup_clock_select_i(startup_clock_select_i), .programming_port_i(programming_port_i),
    .readout_prot_i(readout_prot_i), .readout_prot_removed_i(readout_prot_removed_i),
    .auto_wakeup_halt_i(auto_wakeup_halt_i), .rc_tick_i(rc_tick_i), .awu_tick_i(awu_tick_i),
    .osc_ctrl_o(osc_ctrl_o), .trim_value_o(trim_value_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // oscillator edge pulses: rc every 3 cycles, wakeup rc every 7
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    rc_tick_i <= ((cyc % 3) == 0);
    awu_tick_i <= ((cyc % 7) == 0);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rd_data_o;
    dv = rd_drive_o;
  endtask : rd

  // poll a register until the masked bits match, bounded
  task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 80; i++) begin
      rd(a);
      if ((rv & m) === v) return;
    end
    chk(rv & m, v, "poll bound");
  endtask : poll

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  initial begin
    #(50 * 20000);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    rst_n_i = 1'b0; ce_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0;
    addr_i = '0; wr_data_i = '0; startup_clock_select_i = CKSEL_RC;
    // user cells have no reset: erase them while in reset so first reads are known
    programming_port_i = 1'b0; readout_prot_i = 1'b0; readout_prot_removed_i = 1'b1;
    auto_wakeup_halt_i = 1'b0;
    repeat (11) @(posedge sys_clk_i);
    #1;
    chk(osc_ctrl_o.xtal_en, 1'b1, "crystal runs in reset");
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    readout_prot_removed_i <= 1'b0;
    // reset values and read-only places
    rd(OFS_TRIM_HIGH); chk(rv, TRIM_HIGH_RST, "trim high reset");
    rd(OFS_TRIM_LOW); chk(rv, TRIM_LOW_RST, "trim low reset");
    rd(OFS_PROG_CTRL); chk(rv, 8'h00, "prog ctrl reset");
    chk(trim_value_o, 10'h3ff, "trim out reset");
    wr(OFS_FACT_HIGH, 8'h11);
    wr(OFS_FACT_LOW, 8'h22);
    rd(OFS_FACT_HIGH); chk(rv, 8'h80, "factory high");
    rd(OFS_FACT_LOW); chk(rv, 8'h40, "factory low");
    $display("test reset done");
    // trim value assembly
    wr(OFS_TRIM_HIGH, 8'ha5);
    wr(OFS_TRIM_LOW, 8'h40);
    @(posedge sys_clk_i); #1;
    chk(trim_value_o, {8'ha5, 2'b10}, "trim assembly");
    wr(OFS_TRIM_LOW, 8'h9f);
    @(posedge sys_clk_i); #1;
    chk(trim_value_o, {8'ha5, 2'b00}, "trim low bits only");
    $display("test trim done");
    // user trim programming
    wr(OFS_USER_HIGH, 8'h3c);
    wr(OFS_PROG_CTRL, 8'h01);
    rd(OFS_PROG_CTRL); chk(rv, 8'h00, "program without latch");
    rd(OFS_USER_HIGH); chk(rv, NVM_ERASED, "write without latch dropped");
    wr(OFS_PROG_CTRL, 8'hfe);
    rd(OFS_PROG_CTRL); chk(rv, 8'h02, "latch set, reserved zero");
    rd(OFS_USER_HIGH); chk(dv, 1'b0, "read while latched undriven");
    wr(OFS_USER_HIGH, 8'h5a);
    wr(OFS_USER_LOW, 8'h20);
    wr(OFS_PROG_CTRL, 8'h03);
    rd(OFS_PROG_CTRL); chk(rv, 8'h03, "programming running");
    wr(OFS_PROG_CTRL, 8'h00);
    rd(OFS_PROG_CTRL); chk(rv[LAT_BIT], 1'b1, "latch clear ignored");
    poll(OFS_PROG_CTRL, 8'h03, 8'h00);
    rd(OFS_USER_HIGH); chk({dv, rv}, 9'h15a, "user high stored");
    rd(OFS_USER_LOW); chk({dv, rv[6:5]}, 3'b101, "user low stored");
    $display("test programming done");
    // read-out protection
    readout_prot_i <= 1'b1;
    rd(OFS_USER_HIGH); chk(dv, 1'b0, "protected read");
    wr(OFS_PROG_CTRL, 8'h02);
    wr(OFS_USER_HIGH, 8'h00);
    wr(OFS_PROG_CTRL, 8'h03);
    poll(OFS_PROG_CTRL, 8'h01, 8'h00);
    readout_prot_i <= 1'b0;
    wr(OFS_PROG_CTRL, 8'h00);
    rd(OFS_USER_HIGH); chk(rv, 8'h5a, "protected rewrite blocked");
    // a byte written without latch must not reach the next programming cycle
    wr(OFS_USER_HIGH, 8'h3c);
    wr(OFS_PROG_CTRL, 8'h02);
    wr(OFS_PROG_CTRL, 8'h03);
    poll(OFS_PROG_CTRL, 8'h03, 8'h00);
    rd(OFS_USER_HIGH); chk(rv, 8'h5a, "unlatched write not programmed");
    @(posedge sys_clk_i);
    readout_prot_removed_i <= 1'b1;
    @(posedge sys_clk_i);
    readout_prot_removed_i <= 1'b0;
    rd(OFS_USER_HIGH); chk(rv, NVM_ERASED, "erase high");
    rd(OFS_USER_LOW); chk(rv, NVM_ERASED, "erase low");
    $display("test protection done");
    // clock switch rc to wakeup and back
    rd(OFS_CLK_CSR); chk(rv[2:1], 2'b01, "rc active at start");
    chk(osc_ctrl_o.awu_en, 1'b0, "wakeup osc off");
    auto_wakeup_halt_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i); #1;
    chk(osc_ctrl_o.awu_en, 1'b1, "wakeup osc on in halt");
    auto_wakeup_halt_i <= 1'b0;
    t0 = cyc;
    wr(OFS_CLK_CSR, 8'h01);
    @(posedge sys_clk_i); #1;
    chk(osc_ctrl_o.hold_high, 1'b1, "clock held high");
    rd(OFS_CLK_CSR); chk(rv[2:1], 2'b00, "internal_rc_active_flag dropped");
    poll(OFS_CLK_CSR, 8'h04, 8'h04);
    chk(cyc - t0 >= 14, 1'b1, "three wakeup ticks");
    @(posedge sys_clk_i); #1;
    chk({osc_ctrl_o.rc_en, osc_ctrl_o.src_awu, osc_ctrl_o.hold_high}, 3'b010, "on wakeup");
    t0 = cyc;
    wr(OFS_CLK_CSR, 8'h00);
    poll(OFS_CLK_CSR, 8'h02, 8'h02);
    chk(cyc - t0 >= 30, 1'b1, "eight rc ticks wait");
    chk(rv[2], 1'b0, "wakeup flag cleared");
    @(posedge sys_clk_i); #1;
    chk({osc_ctrl_o.rc_en, osc_ctrl_o.awu_en, osc_ctrl_o.src_awu}, 3'b100, "on rc");
    $display("test clock switch done");
    // programming port forces the internal rc
    wr(OFS_CLK_CSR, 8'h01);
    poll(OFS_CLK_CSR, 8'h04, 8'h04);
    programming_port_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i); #1;
    chk({osc_ctrl_o.rc_en, osc_ctrl_o.src_awu}, 2'b10, "forced rc");
    programming_port_i <= 1'b0;
    $display("test programming port done");
    // startup options through further resets in mid-run
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    startup_clock_select_i <= CKSEL_AWU;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_CLK_CSR); chk(rv[2:0], 3'b101, "wakeup startup flags");
    chk({osc_ctrl_o.rc_en, osc_ctrl_o.src_awu}, 2'b01, "wakeup startup clock");
    rd(OFS_TRIM_HIGH); chk(rv, TRIM_HIGH_RST, "trim back to default after reset");
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    startup_clock_select_i <= 2'b10;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wr(OFS_CLK_CSR, 8'h01);
    rd(OFS_CLK_CSR); chk(rv[2:1], 2'b00, "external startup flags");
    chk({osc_ctrl_o.rc_en, osc_ctrl_o.awu_en, osc_ctrl_o.xtal_en, osc_ctrl_o.src_awu}, 4'b0110, "external clock");
    $display("test startup options done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
